// *** lssl_led_sink.v ***
/*
 Holds the 32-bit serial-in shift register with output latches driving
 open-drain LED sinks, plus a small FIFO carrying serial bits.
 Assumes all inputs but the async i_rst are synchronous to i_ref_clk; shift_clk and
 hold_strobe arrive as sampled levels, preset_n acts synchronously.
*/
`timescale 1ns/10ps
`include "lssl_defines.vh"

module lssl_fifo #(
    parameter WIDTH = 1,
    parameter DEPTH = 4,
    parameter PTR_W = 2,
    parameter CNT_W = 3
) (
    // Clock and reset
    input  wire             i_ref_clk,
    input  wire             i_rst,
    // Fill side
    input  wire [WIDTH-1:0] i_data,
    input  wire             i_valid,
    output wire             o_ready,
    // Drain side
    output wire [WIDTH-1:0] o_data,
    output wire             o_valid,
    input  wire             i_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [PTR_W-1:0] wr_ptr;
    reg [PTR_W-1:0] rd_ptr;
    reg [CNT_W-1:0] count;
    reg             not_full;
    wire            push;
    wire            pop;
    wire [CNT_W-1:0] next_count;

    // Ready comes from a flop so the top output is registered
    assign o_ready = not_full;
    assign next_count = (push & ~pop) ? count + {{(CNT_W-1){1'b0}}, 1'b1}
                      : (pop & ~push) ? count - {{(CNT_W-1){1'b0}}, 1'b1}
                      : count;
    assign o_valid = (count != {CNT_W{1'b0}});
    assign o_data  = mem[rd_ptr];
    assign push    = i_valid & o_ready;
    assign pop     = o_valid & i_ready;

    always @(posedge i_ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_data;
        end
    end

    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_ptr <= {PTR_W{1'b0}};
            rd_ptr <= {PTR_W{1'b0}};
            count  <= {CNT_W{1'b0}};
            not_full <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + {{(PTR_W-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr <= rd_ptr + {{(PTR_W-1){1'b0}}, 1'b1};
            end
            count    <= next_count;
            not_full <= (next_count != DEPTH[CNT_W-1:0]);
        end
    end
endmodule

module lssl_led_sink (
    // Clock and reset
    input  wire                      i_ref_clk,
    input  wire                      i_rst,
    // Serial side
    input  wire                      i_bit_input,
    input  wire                      i_bit_valid,
    output wire                      o_bit_ready,
    input  wire                      i_shift_clk,
    input  wire                      i_hold_strobe,
    input  wire                      i_preset_n,
    input  wire                      i_drive_gate_n,
    // Outputs
    output reg                       o_cascade_out,
    output reg  [`LSSL_MSB:0]        o_led_sink_n_out,
    output reg  [`LSSL_MSB:0]        o_led_sink_n_oe
);
    localparam ST_IDLE = 2'b01;
    localparam ST_HIGH = 2'b10;

    reg  [1:0]          edge_state;
    reg  [`LSSL_MSB:0]  shift_reg;
    reg  [`LSSL_MSB:0]  latch;
    wire                fifo_bit;
    wire                fifo_valid;
    wire                rise;
    wire [`LSSL_MSB:0]  next_shift;
    wire [`LSSL_MSB:0]  next_latch;

    // Sink enable: low drives the pin, gate high floats every sink
    function [`LSSL_MSB:0] sink_enable;
        input [`LSSL_MSB:0] bits;
        input               gate_n;
        begin
            sink_enable = ~bits | {`LSSL_WIDTH{gate_n}};
        end
    endfunction

    lssl_fifo #(
        .WIDTH (1),
        .DEPTH (`LSSL_FIFO_DEPTH),
        .PTR_W (`LSSL_PTR_W),
        .CNT_W (`LSSL_CNT_W)
    ) u_fifo (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_data    (i_bit_input),
        .i_valid   (i_bit_valid),
        .o_ready   (o_bit_ready),
        .o_data    (fifo_bit),
        .o_valid   (fifo_valid),
        .i_ready   (rise)
    );

    // Rising edge of the sampled shift clock
    assign rise = (edge_state == ST_IDLE) & i_shift_clk & fifo_valid;

    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            edge_state <= ST_HIGH;
        end else begin
            case (edge_state)
                ST_IDLE: begin
                    if (i_shift_clk & fifo_valid) begin
                        edge_state <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    if (!i_shift_clk) begin
                        edge_state <= ST_IDLE;
                    end
                end
                default: begin
                    edge_state <= ST_HIGH;
                end
            endcase
        end
    end

    // Stage 1 is bit 0; shifting ignores the output gate
    assign next_shift = rise ? {shift_reg[`LSSL_MSB-1:0], fifo_bit}
                             : shift_reg;
    // Transparent latch: follows register while strobe high
    assign next_latch = i_hold_strobe ? next_shift : latch;

    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            shift_reg <= `LSSL_SET_ALL;
            latch     <= `LSSL_SET_ALL;
        end else if (!i_preset_n) begin
            shift_reg <= `LSSL_SET_ALL;
            latch     <= `LSSL_SET_ALL;
        end else begin
            shift_reg <= next_shift;
            latch     <= next_latch;
        end
    end

    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cascade_out    <= `LSSL_ONE_BIT;
            o_led_sink_n_out <= {`LSSL_WIDTH{`LSSL_ZERO_BIT}};
            o_led_sink_n_oe  <= `LSSL_SET_ALL;
        end else begin
            o_led_sink_n_out <= {`LSSL_WIDTH{`LSSL_ZERO_BIT}};
            if (!i_preset_n) begin
                o_cascade_out   <= `LSSL_ONE_BIT;
                o_led_sink_n_oe <= sink_enable(`LSSL_SET_ALL,
                                               i_drive_gate_n);
            end else begin
                o_cascade_out   <= next_shift[`LSSL_MSB];
                // Enable is low to sink; one sinks, zero floats
                o_led_sink_n_oe <= sink_enable(next_latch,
                                               i_drive_gate_n);
            end
        end
    end
endmodule

// *** lssl_defines.vh ***
/*
 Constants for the 32-bit LED sink shift and latch block.
 Assumes inclusion by its bare name from the design file.
*/
`ifndef LSSL_DEFINES_VH
`define LSSL_DEFINES_VH
`define LSSL_WIDTH      32
`define LSSL_MSB        31
`define LSSL_FIFO_DEPTH 4
`define LSSL_PTR_W      2
`define LSSL_CNT_W      3
`define LSSL_SET_ALL    32'hffffffff
`define LSSL_ZERO_BIT   1'b0
`define LSSL_ONE_BIT    1'b1
`endif

// *** lssl_assertions.sv ***
/* Port checks for lssl_led_sink; assumes one clock, async high reset. */
`timescale 1ns/10ps
module lssl_chk (
    input wire logic i_ref_clk, i_rst, i_shift_clk, i_hold_strobe,
    input wire logic i_preset_n, i_drive_gate_n, o_cascade_out,
    input wire logic [31:0] o_led_sink_n_out, o_led_sink_n_oe
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    sequence calm;
        i_hold_strobe && !i_shift_clk && i_preset_n && !i_drive_gate_n;
    endsequence
    latch_track_a: assert property (calm ##1 calm |=>
        o_led_sink_n_oe[31] == !o_cascade_out) else $error("track");
    cascade_cause_a: assert property ($changed(o_cascade_out) |->
        $past(i_shift_clk) || !$past(i_preset_n)) else $error("shift");
    latch_hold_a: assert property (!i_hold_strobe && i_preset_n &&
        !$past(i_rst) && !$past(i_rst, 2) && $stable(i_drive_gate_n)
        |=> $stable(o_led_sink_n_oe)) else $error("hold");
    gate_off_a: assert property (i_drive_gate_n |=> &o_led_sink_n_oe)
        else $error("gate");
    gate_cause_a: assert property (!(&o_led_sink_n_oe) |->
        !$past(i_drive_gate_n)) else $error("sink");
    preset_sink_a: assert property (!i_preset_n && !$past(i_rst)
        && !i_drive_gate_n |=> o_led_sink_n_oe == 32'h0) else $error("set");
    preset_cas_a: assert property (!i_preset_n |=> o_cascade_out)
        else $error("set");
    sink_low_a: assert property (o_led_sink_n_out == 32'h0)
        else $error("high");
endmodule
bind lssl_led_sink lssl_chk chk_u (.*);

// *** lssl_led_load.sv ***
/* Pulled-up LED load on the open-drain sinks; low enable drives the pin. */
`timescale 1ns/10ps
module lssl_led_load (
    input  wire logic [31:0] i_oe, i_out,
    output wire logic [31:0] o_pin
);
    assign o_pin = i_oe | i_out;
endmodule

// *** lssl_led_sink_tb_top.sv ***
/* Bench for lssl_led_sink with LED load; inputs move 1 ns after rising clock edges. */
`timescale 1ns/10ps
module lssl_led_sink_tb_top;
    localparam logic [31:0] W = 32'h23a50f81;
    logic c = 0, r = 1, d = 0, v = 0, s = 0, h = 0, p = 1, g = 1, rdy, q;
    logic [31:0] so, oe, pin;
    int n_fail = 0, comparisons = 0;
    lssl_led_sink dut_u (.i_ref_clk(c), .i_rst(r), .i_bit_input(d),
        .i_bit_valid(v), .o_bit_ready(rdy), .i_shift_clk(s),
        .i_hold_strobe(h), .i_preset_n(p), .i_drive_gate_n(g),
        .o_cascade_out(q), .o_led_sink_n_out(so), .o_led_sink_n_oe(oe));
    lssl_led_load load_u (.i_oe(oe), .i_out(so), .o_pin(pin));
    initial forever #50 c = ~c;
    task automatic t(int n = 1);
        repeat (n) @(posedge c);
        #1;
    endtask
    task automatic chk(logic ok);
        comparisons++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("Error %0t: output mismatch", $time);
        end
    endtask
    task automatic end_sim;
        $display("compares %0d, errors %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic pulse(int n); // Shift clock high one cycle, low one
        repeat (n) begin
            s = 1;
            t();
            s = 0;
            t();
        end
    endtask
    task automatic push(logic b);
        d = b;
        v = 1;
        t();
    endtask
    initial begin
        t(5);
        r = 0;
        t();
        chk(q === 1'b1 && pin === '1);
        for (int i = 31; i >= 0; i--) begin
            push(W[i]);
            if (i % 4 == 0) begin
                v = 0;
                chk(rdy === 1'b0);
                pulse(4);
            end
        end
        chk(q === W[31] && pin === '1);
        g = 0;
        h = 1;
        t(2);
        h = 0;
        chk(pin === ~W && so === '0);
        push(1'b1);
        v = 0;
        pulse(1);
        chk(q === W[30] && pin === ~W);
        g = 1;
        t();
        chk(pin === '1 && q === W[30]);
        g = 0;
        p = 0;
        t(2);
        chk(pin === '0 && q === 1'b1);
        end_sim();
    end
    initial begin
        t(3000);
        chk(1'b0);
        end_sim();
    end
endmodule
